// File: src/oslp_consts.vh
`ifndef OSLP_CONSTS_VH
`define OSLP_CONSTS_VH
// Register byte offsets
`define OSLP_CTRL_OFS     8'h00
`define OSLP_MEPID_OFS    8'h04
`define OSLP_STICKY_OFS   8'h08
`define OSLP_TXFRM_OFS    8'h0c
`define OSLP_EXTR_OFS     8'h10
`define OSLP_PEER_OFS     8'h20
`define OSLP_TXLOSS_OFS   8'h40
`define OSLP_RXLOSS_OFS   8'h60
// Control register fields
`define OSLP_C_OAMCNT     0
`define OSLP_C_LOOP       1
`define OSLP_C_REQCPY     2
`define OSLP_C_RPLCPY     3
`define OSLP_C_INSERT     4
`define OSLP_C_EXTTS      5
`define OSLP_C_DMMHW      6
`define OSLP_C_DMRHW      7
`define OSLP_C_DOM_LO     8
`define OSLP_CTRL_RST     32'h0000_0000
// Sticky flag positions
`define OSLP_S_SLM        0
`define OSLP_S_SLR        1
`define OSLP_S_1SL        2
// Extract register: one-shot bit above the per-peer bits
`define OSLP_X_ONESHOT    8
// Peer entry: enable bit above the identifier
`define OSLP_P_ENA        13
// Frame types on the lookup port
`define OSLP_T_SLM        3'h0
`define OSLP_T_SLR        3'h1
`define OSLP_T_1SL        3'h2
`define OSLP_T_DMM        3'h3
`define OSLP_T_DMR        3'h4
`define OSLP_T_1DM        3'h5
// Field selectors on the result port
`define OSLP_F_NONE       2'h0
`define OSLP_F_TXFCF      2'h1
`define OSLP_F_TXFCB      2'h2
`define OSLP_F_RXFC       2'h3
// Reply rewrite constants and the timestamp domain count
`define OSLP_TLV_OFS      8'h14
`define OSLP_END_TLV      8'h00
`define OSLP_DOMAINS      2'h3
`endif

// File: src/oslp_endpoint.v
`timescale 1ns/10ps
`include "oslp_consts.vh"
// How it works
// - Tx SLM stamps TxFCf, then counts up
// - Tx 1SL stamps TxFCf, then counts up
// - Rx SLM sets its sticky flag
// - Rx SLM counted per OAM-count enable
// - Loopback turns Rx SLM into SLR
// - Request copy enable copies Rx SLM from listed peers
// - Tx SLR stamps peer Tx loss count
// - Peer Tx loss count increments afterwards
// - Tx SLR responder id becomes local id
// - Rx SLR sets its sticky flag
// - Insert mode sets TLV offset 20
// - Insert mode adds RxFCb, then counts up
// - Insert mode appends zero End TLV
// - Per-peer extract, optionally one shot
// - Reply copy enable copies SLR and 1SL
// - Rx 1SL sets its sticky flag
// - Rx 1SL stamps peer Rx count, counts up
// - One delay type at a time, by frames
// - External stamping leaves timestamps untouched
// - Down endpoints stamp like PTP
// - Up endpoints stamp received frames at modifiers
// - Port mapped to one of three domains
// - Delay hw disabled leaves frames unmodified
// - Peer index from eight-row list
module oslp_endpoint #(
  parameter PEERS = 8
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // AXI4-Lite write channels
  input  wire [7:0]  s_axi_awaddr_in,
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  output reg  [1:0]  s_axi_bresp_out,
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  // AXI4-Lite read channels
  input  wire [7:0]  s_axi_araddr_in,
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out,
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  // Lookup request from the frame pipeline
  input  wire        lkp_valid_in,
  input  wire        lkp_rx_in,
  input  wire [2:0]  lkp_type_in,
  input  wire [12:0] lkp_mepid_in,
  input  wire        lkp_up_in,
  // Lookup result, one cycle later
  output reg         res_valid_out,
  output reg         res_invalid_out,
  output reg  [1:0]  res_field_sel_out,
  output reg  [31:0] res_field_data_out,
  output reg         res_rsp_mepid_wr_out,
  output reg  [12:0] res_rsp_mepid_out,
  output reg         res_insert_out,
  output reg  [7:0]  res_tlv_offset_out,
  output reg  [7:0]  res_end_tlv_out,
  output reg         res_loop_out,
  output reg         res_cpu_copy_out,
  output reg         res_oam_selected_out,
  output reg         res_ts_write_out,
  output reg         res_ts_ptp_out,
  output reg         res_ts_rew_out,
  output reg  [1:0]  res_ts_domain_out
);
  //////////////////////////////////////////////////////////////////////////////
  reg        rst_meta_q;
  reg        rst_sync_q;
  reg [31:0] ctrl_q;
  reg [12:0] local_mepid_q;
  reg [2:0]  sticky_q;
  reg [31:0] tx_frame_q;
  reg [PEERS-1:0] extract_q;
  reg        one_shot_q;
  reg [PEERS-1:0] peer_ena_q;
  reg [PEERS*13-1:0] peer_id_q;
  reg [31:0] tx_loss_q [0:PEERS-1];
  reg [31:0] rx_loss_q [0:PEERS-1];
  integer    k;

  // Two-stage release of the asynchronous reset
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshakes: write address and data taken together
  wire wr_go = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
  wire rd_go = s_axi_arvalid_in & ~s_axi_rvalid_out;
  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out  = wr_go;
  assign s_axi_arready_out = rd_go;

  // Byte-lane merge of write data
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (be[b])
          merge[b*8 +: 8] = nw[b*8 +: 8];
    end
  endfunction

  // Register decode shared by read and write
  function [2:0] region;
    input [7:0] a;
    begin
      if (a[1:0] != 2'h0)
        region = 3'h7;
      else if (a < `OSLP_PEER_OFS)
        region = (a <= `OSLP_EXTR_OFS) ? 3'h0 : 3'h7;
      else if (a < `OSLP_TXLOSS_OFS)
        region = 3'h1;
      else if (a < `OSLP_RXLOSS_OFS)
        region = 3'h2;
      else if (a < 8'h80)
        region = 3'h3;
      else
        region = 3'h7;
    end
  endfunction

  wire [2:0] wr_reg = region(s_axi_awaddr_in);
  wire [2:0] rd_reg = region(s_axi_araddr_in);
  wire [2:0] wr_row = s_axi_awaddr_in[4:2];
  wire [2:0] rd_row = s_axi_araddr_in[4:2];
  wire       wr_ok  = (wr_reg != 3'h7) && (wr_reg != 3'h2) && (wr_reg != 3'h3);
  wire [31:0] mepid_wr = merge({19'h0, local_mepid_q}, s_axi_wdata_in, s_axi_wstrb_in);

  //////////////////////////////////////////////////////////////////////////////
  // Peer lookup
  wire       peer_hit;
  wire [2:0] peer_idx;

  oslp_peer_match #(
    .PEERS (PEERS),
    .IW    (13)
  ) u_match (
    .peer_ena_in (peer_ena_q),
    .peer_id_in  (peer_id_q),
    .mepid_in    (lkp_mepid_in),
    .hit_out     (peer_hit),
    .index_out   (peer_idx)
  );

  // Frame classification; the delay type follows the frames alone
  wire is_slm  = lkp_type_in == `OSLP_T_SLM;
  wire is_slr  = lkp_type_in == `OSLP_T_SLR;
  wire is_1sl  = lkp_type_in == `OSLP_T_1SL;
  wire is_dmm  = (lkp_type_in == `OSLP_T_DMM) | (lkp_type_in == `OSLP_T_1DM);
  wire is_dmr  = lkp_type_in == `OSLP_T_DMR;
  wire is_sl   = is_slm | is_slr | is_1sl;
  wire need_pr = is_sl & ~(~lkp_rx_in & (is_slm | is_1sl));
  wire bad     = need_pr & ~peer_hit;
  wire good    = lkp_valid_in & ~bad;
  wire tx_cnt  = good & ~lkp_rx_in & (is_slm | is_1sl);
  wire tx_slr  = good & ~lkp_rx_in & is_slr;
  wire rx_slr  = good & lkp_rx_in & is_slr;
  wire rx_1sl  = good & lkp_rx_in & is_1sl;
  wire rx_slm  = good & lkp_rx_in & is_slm;
  wire rx_ins  = rx_slr & ctrl_q[`OSLP_C_INSERT];
  wire rx_bump = rx_ins | rx_1sl;
  wire peer_x  = (rx_slr | rx_1sl) & extract_q[peer_idx];
  wire dm_hw   = (is_dmm & ctrl_q[`OSLP_C_DMMHW]) | (is_dmr & ctrl_q[`OSLP_C_DMRHW]);

  //////////////////////////////////////////////////////////////////////////////
  // Software registers and hardware-updated state
  always @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ctrl_q        <= `OSLP_CTRL_RST;
      local_mepid_q <= 13'h0000;
      sticky_q      <= 3'h0;
      tx_frame_q    <= 32'h0000_0000;
      extract_q     <= {PEERS{1'b0}};
      one_shot_q    <= 1'b0;
      peer_ena_q    <= {PEERS{1'b0}};
      peer_id_q     <= {(PEERS*13){1'b0}};
    end
    else
    begin
      if (wr_go && wr_reg == 3'h0)
      begin
        case (s_axi_awaddr_in)
          `OSLP_CTRL_OFS:
            ctrl_q <= merge(ctrl_q, s_axi_wdata_in, s_axi_wstrb_in);
          `OSLP_MEPID_OFS:
            local_mepid_q <= mepid_wr[12:0];
          `OSLP_STICKY_OFS:
            if (s_axi_wstrb_in[0])
              sticky_q <= sticky_q & ~s_axi_wdata_in[2:0];
          `OSLP_TXFRM_OFS:
            tx_frame_q <= merge(tx_frame_q, s_axi_wdata_in, s_axi_wstrb_in);
          `OSLP_EXTR_OFS:
          begin
            if (s_axi_wstrb_in[0])
              extract_q <= s_axi_wdata_in[PEERS-1:0];
            if (s_axi_wstrb_in[1])
              one_shot_q <= s_axi_wdata_in[`OSLP_X_ONESHOT];
          end
          default:
            ctrl_q <= ctrl_q;
        endcase
      end
      else if (wr_go && wr_reg == 3'h1)
      begin
        if (s_axi_wstrb_in[0])
          peer_id_q[wr_row*13 +: 8] <= s_axi_wdata_in[7:0];
        if (s_axi_wstrb_in[1])
        begin
          peer_id_q[wr_row*13+8 +: 5] <= s_axi_wdata_in[12:8];
          peer_ena_q[wr_row]          <= s_axi_wdata_in[`OSLP_P_ENA];
        end
      end
      // Hardware sets after the clear so an event in the clear cycle wins
      if (rx_slm)
        sticky_q[`OSLP_S_SLM] <= 1'b1;
      if (rx_slr)
        sticky_q[`OSLP_S_SLR] <= 1'b1;
      if (rx_1sl)
        sticky_q[`OSLP_S_1SL] <= 1'b1;
      if (tx_cnt)
        tx_frame_q <= tx_frame_q + 32'h0000_0001;
      if (peer_x && one_shot_q)
        extract_q[peer_idx] <= 1'b0;
    end
  end

  // Per-peer loss counters, bumped after their value is sampled
  always @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      for (k = 0; k < PEERS; k = k + 1)
      begin
        tx_loss_q[k] <= 32'h0000_0000;
        rx_loss_q[k] <= 32'h0000_0000;
      end
    end
    else
    begin
      if (tx_slr)
        tx_loss_q[peer_idx] <= tx_loss_q[peer_idx] + 32'h0000_0001;
      if (rx_bump)
        rx_loss_q[peer_idx] <= rx_loss_q[peer_idx] + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write response; unmapped or read-only targets answer SLVERR
  always @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= 2'h0;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_ok ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // Read data mux
  reg [31:0] rd_data;
  always @*
  begin
    rd_data = 32'h0000_0000;
    case (rd_reg)
      3'h0:
        case (s_axi_araddr_in)
          `OSLP_CTRL_OFS:   rd_data = ctrl_q;
          `OSLP_MEPID_OFS:  rd_data = {19'h0, local_mepid_q};
          `OSLP_STICKY_OFS: rd_data = {29'h0, sticky_q};
          `OSLP_TXFRM_OFS:  rd_data = tx_frame_q;
          `OSLP_EXTR_OFS:   rd_data = {23'h0, one_shot_q, extract_q};
          default:          rd_data = 32'h0000_0000;
        endcase
      3'h1:
        rd_data = {18'h0, peer_ena_q[rd_row], peer_id_q[rd_row*13 +: 13]};
      3'h2:
        rd_data = tx_loss_q[rd_row];
      3'h3:
        rd_data = rx_loss_q[rd_row];
      default:
        rd_data = 32'h0000_0000;
    endcase
  end

  // Read response, registered
  always @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= 2'h0;
    end
    else if (rd_go)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= rd_data;
      s_axi_rresp_out  <= (rd_reg == 3'h7) ? 2'h2 : 2'h0;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lookup result, registered one cycle after the request
  always @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      res_valid_out        <= 1'b0;
      res_invalid_out      <= 1'b0;
      res_field_sel_out    <= `OSLP_F_NONE;
      res_field_data_out   <= 32'h0000_0000;
      res_rsp_mepid_wr_out <= 1'b0;
      res_rsp_mepid_out    <= 13'h0000;
      res_insert_out       <= 1'b0;
      res_tlv_offset_out   <= 8'h00;
      res_end_tlv_out      <= 8'h00;
      res_loop_out         <= 1'b0;
      res_cpu_copy_out     <= 1'b0;
      res_oam_selected_out <= 1'b0;
      res_ts_write_out     <= 1'b0;
      res_ts_ptp_out       <= 1'b0;
      res_ts_rew_out       <= 1'b0;
      res_ts_domain_out    <= 2'h0;
    end
    else
    begin
      res_valid_out        <= lkp_valid_in;
      res_invalid_out      <= lkp_valid_in & bad;
      res_field_sel_out    <= `OSLP_F_NONE;
      res_field_data_out   <= 32'h0000_0000;
      res_rsp_mepid_wr_out <= tx_slr;
      res_rsp_mepid_out    <= local_mepid_q;
      res_insert_out       <= rx_ins;
      res_tlv_offset_out   <= rx_ins ? `OSLP_TLV_OFS : 8'h00;
      res_end_tlv_out      <= `OSLP_END_TLV;
      res_loop_out         <= rx_slm & ctrl_q[`OSLP_C_LOOP];
      res_cpu_copy_out     <= (rx_slm & ctrl_q[`OSLP_C_REQCPY])
                            | ((rx_slr | rx_1sl) & ctrl_q[`OSLP_C_RPLCPY])
                            | peer_x;
      res_oam_selected_out <= rx_slm & ctrl_q[`OSLP_C_OAMCNT];
      // Timestamps only with internal stamping and delay hw enabled
      res_ts_write_out     <= lkp_valid_in & dm_hw & ~ctrl_q[`OSLP_C_EXTTS];
      res_ts_ptp_out       <= ~lkp_up_in;
      res_ts_rew_out       <= lkp_up_in & lkp_rx_in;
      // Domain 3 is not a domain and falls back to 0
      res_ts_domain_out    <= (ctrl_q[`OSLP_C_DOM_LO +: 2] == `OSLP_DOMAINS) ? 2'h0
                            : ctrl_q[`OSLP_C_DOM_LO +: 2];
      if (tx_cnt)
      begin
        res_field_sel_out  <= `OSLP_F_TXFCF;
        res_field_data_out <= tx_frame_q;
      end
      else if (tx_slr)
      begin
        res_field_sel_out  <= `OSLP_F_TXFCB;
        res_field_data_out <= tx_loss_q[peer_idx];
      end
      else if (rx_bump)
      begin
        res_field_sel_out  <= `OSLP_F_RXFC;
        res_field_data_out <= rx_loss_q[peer_idx];
      end
    end
  end
endmodule // oslp_endpoint

// File: src/oslp_peer_match.v
`timescale 1ns/10ps
// Finds the peer list row that holds a given endpoint identifier
module oslp_peer_match #(
  parameter PEERS = 8,
  parameter IW    = 13
) (
  // Peer list, one entry of enable and identifier per row
  input  wire [PEERS-1:0]    peer_ena_in,
  input  wire [PEERS*IW-1:0] peer_id_in,
  // Identifier to look up
  input  wire [IW-1:0]       mepid_in,
  // Lowest matching row
  output reg                 hit_out,
  output reg  [2:0]          index_out
);
  wire [PEERS-1:0] match;
  integer          i;

  // Compare every row at once
  genvar g;
  generate
    for (g = 0; g < PEERS; g = g + 1)
    begin : row
      assign match[g] = peer_ena_in[g] & (peer_id_in[g*IW +: IW] == mepid_in);
    end
  endgenerate

  // Priority encode, lowest row wins
  always @*
  begin
    hit_out   = 1'b0;
    index_out = 3'h0;
    for (i = PEERS - 1; i >= 0; i = i - 1)
      if (match[i])
      begin
        hit_out   = 1'b1;
        index_out = i[2:0];
      end
  end
endmodule // oslp_peer_match

// File: verification/oslp_endpoint_properties.sv
`timescale 1ns/10ps
`include "oslp_consts.vh"
// Port-level checks on lookup results and bus answers
module oslp_endpoint_properties (
  // Clock and reset
  input wire        clk_in,
  input wire        rst_n_in,
  // Lookup side
  input wire        lkp_valid_in,
  input wire        lkp_rx_in,
  input wire [2:0]  lkp_type_in,
  input wire        lkp_up_in,
  // Result side
  input wire        res_valid_out,
  input wire [1:0]  res_field_sel_out,
  input wire        res_rsp_mepid_wr_out,
  input wire        res_insert_out,
  input wire [7:0]  res_tlv_offset_out,
  input wire [7:0]  res_end_tlv_out,
  input wire        res_ts_write_out,
  input wire        res_ts_rew_out,
  input wire [1:0]  res_ts_domain_out,
  // Write response
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  res_echo_a: assert property (lkp_valid_in |=> res_valid_out)
    else $error("lookup without result");
  res_quiet_a: assert property (!lkp_valid_in |=> !res_valid_out)
    else $error("result without lookup");
  txfcf_stamp_a: assert property (lkp_valid_in && !lkp_rx_in &&
    (lkp_type_in == `OSLP_T_SLM || lkp_type_in == `OSLP_T_1SL)
    |=> res_field_sel_out == `OSLP_F_TXFCF) else $error("forward count not stamped");
  rsp_id_src_a: assert property (res_rsp_mepid_wr_out |->
    $past(lkp_type_in) == `OSLP_T_SLR && !$past(lkp_rx_in)) else $error("stray id write");
  tlv_offset_a: assert property (res_insert_out |->
    res_tlv_offset_out == `OSLP_TLV_OFS && res_field_sel_out == `OSLP_F_RXFC)
    else $error("bad reply rewrite");
  end_tlv_a: assert property (res_valid_out |-> res_end_tlv_out == `OSLP_END_TLV)
    else $error("end marker not zero");
  domain_range_a: assert property (res_ts_write_out |-> res_ts_domain_out != 2'h3)
    else $error("domain out of range");
  ts_delay_only_a: assert property (res_ts_write_out |-> $past(lkp_type_in) >= `OSLP_T_DMM)
    else $error("stamp on non-delay frame");
  rew_point_a: assert property (res_ts_rew_out |-> $past(lkp_up_in) && $past(lkp_rx_in))
    else $error("wrong stamp point");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("write answer dropped");
  // Main scenarios reached
  c_insert: cover property (res_insert_out);
  c_rew: cover property (res_ts_write_out && res_ts_rew_out);
  c_rspid: cover property (res_rsp_mepid_wr_out);
  c_bwait: cover property (s_axi_bvalid_out && !s_axi_bready_in);
endmodule // oslp_endpoint_properties
bind oslp_endpoint oslp_endpoint_properties i_oslp_endpoint_properties (.*);

// File: verification/oslp_peer_model.sv
`timescale 1ns/10ps
// Peer endpoint: turns bench requests into single lookup pulses
module oslp_peer_model (
  // Clock and request from the bench
  input  wire        clk_in,
  input  wire        req_in,
  input  wire        rx_in,
  input  wire [2:0]  type_in,
  input  wire [12:0] mepid_in,
  input  wire        up_in,
  // Lookup port of the endpoint
  output reg         lkp_valid_out = 1'b0,
  output reg         lkp_rx_out    = 1'b0,
  output reg  [2:0]  lkp_type_out  = 3'h0,
  output reg  [12:0] lkp_mepid_out = 13'h0000,
  output reg         lkp_up_out    = 1'b0
);
  // One frame per request; idle type and identifier toggle so no stale value lingers
  always @(posedge clk_in)
  begin
    lkp_valid_out <= req_in;
    if (req_in)
    begin
      lkp_rx_out    <= rx_in;
      lkp_type_out  <= type_in;
      lkp_mepid_out <= mepid_in;
      lkp_up_out    <= up_in;
    end
    else
    begin
      lkp_type_out  <= ~lkp_type_out;
      lkp_mepid_out <= ~lkp_mepid_out;
    end
  end
endmodule // oslp_peer_model

// File: verification/test_oslp_endpoint.sv
`timescale 1ns/10ps
`include "oslp_consts.vh"
module test_oslp_endpoint;
  typedef struct packed {logic [9:0] c; logic rx; logic [2:0] t; logic up; logic [4:0] e;} oslp_row_t;
  // Delay rows: control, direction, type, facing, then write/ptp/rew/domain
  oslp_row_t rows [7] = '{'{10'h040, 1'b0, 3'h3, 1'b0, 5'h18}, '{10'h060, 1'b0, 3'h3, 1'b0, 5'h00},
    '{10'h000, 1'b0, 3'h3, 1'b0, 5'h00}, '{10'h080, 1'b1, 3'h4, 1'b1, 5'h14},
    '{10'h280, 1'b0, 3'h4, 1'b1, 5'h12}, '{10'h340, 1'b1, 3'h5, 1'b0, 5'h18},
    '{10'h140, 1'b0, 3'h5, 1'b0, 5'h19}};
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        req = 1'b0, rx = 1'b0, up = 1'b0;
  logic [2:0]  typ = 3'h0;
  logic [12:0] id = 13'h0;
  int          miscompares = 0, n_compared = 0, i;
  wire         awrdy, wrdy, bvalid, arrdy, rvalid, lv, lr, lu;
  wire         inv, rwr, ins, lp, cp, os, tw, tp, tr;
  wire [1:0]   bresp, rresp, sel, dom;
  wire [2:0]   lt;
  wire [12:0]  lm, rsp;
  wire [31:0]  rdata, fd;
  wire [7:0]   tlv, et;
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz
  always #12.5 clk_in = ~clk_in;
  oslp_peer_model i_oslp_peer_model (.clk_in(clk_in), .req_in(req), .rx_in(rx), .type_in(typ),
    .mepid_in(id), .up_in(up), .lkp_valid_out(lv), .lkp_rx_out(lr), .lkp_type_out(lt),
    .lkp_mepid_out(lm), .lkp_up_out(lu));
  oslp_endpoint i_oslp_endpoint (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awrdy),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .lkp_valid_in(lv), .lkp_rx_in(lr),
    .lkp_type_in(lt), .lkp_mepid_in(lm), .lkp_up_in(lu), .res_valid_out(),
    .res_invalid_out(inv), .res_field_sel_out(sel), .res_field_data_out(fd),
    .res_rsp_mepid_wr_out(rwr), .res_rsp_mepid_out(rsp), .res_insert_out(ins),
    .res_tlv_offset_out(tlv), .res_end_tlv_out(et), .res_loop_out(lp), .res_cpu_copy_out(cp),
    .res_oam_selected_out(os), .res_ts_write_out(tw), .res_ts_ptp_out(tp),
    .res_ts_rew_out(tr), .res_ts_domain_out(dom));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] s, input [31:0] e);
  begin
    n_compared++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, e);
    end
  end
  endtask
  task end_sim;
  begin
    if (miscompares == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  // Register write: address and data offered together, response awaited
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
  begin
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk_in); while (!(awrdy === 1'b1 && wrdy === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // Response left waiting one cycle so it must stand
    @(posedge clk_in);
    bready <= 1'b1;
    do @(posedge clk_in); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  end
  endtask
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
  begin
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_in); while (arrdy !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  end
  endtask
  // One frame from the peer; results sampled in the cycle they stand
  task lk(input r, input [2:0] t, input [12:0] m, input u);
  begin
    @(posedge clk_in);
    req <= 1'b1;
    rx <= r;
    typ <= t;
    id <= m;
    up <= u;
    @(posedge clk_in);
    req <= 1'b0;
    @(posedge clk_in);
    @(negedge clk_in);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #100000;
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(`OSLP_CTRL_OFS, `OSLP_CTRL_RST, 2'h0);
    rd(`OSLP_STICKY_OFS, 32'h0, 2'h0);
    wr(`OSLP_PEER_OFS, 32'h2011, 2'h0);
    wr(8'h24, 32'h2022, 2'h0);
    wr(`OSLP_MEPID_OFS, 32'h155, 2'h0);
    wr(`OSLP_TXFRM_OFS, 32'hffff_fffe, 2'h0);
    // Ordinary rows: every request-flag combination on a received request
    for (i = 0; i < 8; i++)
    begin
      wr(`OSLP_CTRL_OFS, 32'(i), 2'h0);
      lk(1'b1, `OSLP_T_SLM, 13'h011, 1'b0);
      chk(32'({os, lp, cp}), 32'({i[0], i[1], i[2]}));
    end
    // Delay rows
    for (i = 0; i < 7; i++)
    begin
      wr(`OSLP_CTRL_OFS, 32'(rows[i].c), 2'h0);
      lk(rows[i].rx, rows[i].t, 13'h011, rows[i].up);
      chk(32'(tw), 32'(rows[i].e[4]));
      if (rows[i].e[4]) chk(32'({tp, tr, dom}), 32'(rows[i].e[3:0]));
    end
    wr(`OSLP_CTRL_OFS, 32'h0, 2'h0);
    lk(1'b0, `OSLP_T_SLM, 13'h011, 1'b0);
    chk(32'(sel), 32'(`OSLP_F_TXFCF));
    chk(fd, 32'hffff_fffe);
    lk(1'b0, `OSLP_T_1SL, 13'h011, 1'b0);
    chk(fd, 32'hffff_ffff);
    lk(1'b0, `OSLP_T_SLM, 13'h011, 1'b0);
    chk(fd, 32'h0);
    rd(`OSLP_TXFRM_OFS, 32'h1, 2'h0);
    lk(1'b0, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(32'({rwr, rsp}), 32'h2155);
    chk(32'(sel), 32'(`OSLP_F_TXFCB));
    chk(fd, 32'h0);
    lk(1'b0, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(fd, 32'h1);
    rd(8'h44, 32'h2, 2'h0);
    wr(`OSLP_TXLOSS_OFS, 32'h5, 2'h2);
    rd(8'h1c, 32'h0, 2'h2);
    lk(1'b1, `OSLP_T_SLM, 13'h0333, 1'b0);
    chk(32'(inv), 32'h1);
    wr(`OSLP_CTRL_OFS, 32'h10, 2'h0);
    lk(1'b1, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(32'({ins, tlv, et}), 32'h114_00);
    chk(32'(sel), 32'(`OSLP_F_RXFC));
    chk(fd, 32'h0);
    lk(1'b1, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(fd, 32'h1);
    wr(`OSLP_CTRL_OFS, 32'h0, 2'h0);
    lk(1'b1, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(32'({ins, tlv}), 32'h0);
    lk(1'b1, `OSLP_T_1SL, 13'h011, 1'b0);
    chk(32'(sel), 32'(`OSLP_F_RXFC));
    chk(fd, 32'h0);
    rd(`OSLP_STICKY_OFS, 32'h7, 2'h0);
    wr(`OSLP_STICKY_OFS, 32'h7, 2'h0);
    rd(`OSLP_STICKY_OFS, 32'h0, 2'h0);
    wr(`OSLP_EXTR_OFS, 32'h101, 2'h0);
    lk(1'b1, `OSLP_T_1SL, 13'h011, 1'b0);
    chk(32'(cp), 32'h1);
    lk(1'b1, `OSLP_T_1SL, 13'h011, 1'b0);
    chk(32'(cp), 32'h0);
    rd(`OSLP_EXTR_OFS, 32'h100, 2'h0);
    wr(`OSLP_CTRL_OFS, 32'h8, 2'h0);
    lk(1'b1, `OSLP_T_SLR, 13'h022, 1'b0);
    chk(32'(cp), 32'h1);
    // Reset in mid-run clears counters and flags
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(`OSLP_TXFRM_OFS, 32'h0, 2'h0);
    rd(`OSLP_STICKY_OFS, 32'h0, 2'h0);
    rd(8'h44, 32'h0, 2'h0);
    end_sim();
  end
endmodule // test_oslp_endpoint
